// ==== rtl/flash_host.v ====
`timescale 1ns/10ps
`include "flash_host_defs.vh"
module flash_host (
  clk,
  rst,
  op_valid,
  op_code,
  op_addr,
  op_data,
  op_ready,
  done,
  timeout,
  rd_data,
  locked,
  ce_n,
  oe_n,
  we_n,
  addr,
  dq_out,
  dq_in,
  dq_oe_n
);
  input wire clk;
  input wire rst;
  input wire op_valid;
  input wire [2:0] op_code;
  input wire [`ADDR_W-1:0] op_addr;
  input wire [`DATA_W-1:0] op_data;
  output wire op_ready;
  output reg done;
  output reg timeout;
  output reg [`DATA_W-1:0] rd_data;
  output reg locked;
  output reg ce_n;
  output reg oe_n;
  output reg we_n;
  output reg [`ADDR_W-1:0] addr;
  output reg [`DATA_W-1:0] dq_out;
  input wire [`DATA_W-1:0] dq_in;
  output reg dq_oe_n;

  localparam S_IDLE = 3'h0;
  localparam S_WSET = 3'h1;
  localparam S_WPULSE = 3'h2;
  localparam S_WHOLD = 3'h3;
  localparam S_RSET = 3'h4;
  localparam S_RPULSE = 3'h5;
  localparam S_RHOLD = 3'h6;
  localparam S_GAP = 3'h7;

  reg [2:0] state_reg;
  reg [2:0] op_reg;
  reg [`ADDR_W-1:0] taddr_reg;
  reg [`DATA_W-1:0] tdata_reg;
  reg [1:0] phase_reg;
  reg [2:0] seq_reg;
  reg [2:0] tcnt_reg;
  reg [24:0] wait_reg;
  reg [`DATA_W-1:0] last_reg;
  reg have_last_reg;
  reg polling_reg;
  wire [`ADDR_W-1:0] seq_addr;

  function [`DATA_W-1:0] cmd_of;
    input [2:0] op;
    input [1:0] ph;
    begin
      case (op)
        `OP_PROGRAM: cmd_of = `CMD_PROGRAM_SETUP;
        `OP_SECTOR_ERASE: cmd_of = (ph == 2'h0) ? `CMD_SECTOR_SETUP : `CMD_SECTOR_EXEC;
        `OP_CHIP_ERASE: cmd_of = (ph == 2'h0) ? `CMD_CHIP_SETUP : `CMD_CHIP_EXEC;
        default: cmd_of = `CMD_RESET;
      endcase
    end
  endfunction

  function [24:0] limit_of;
    input [2:0] op;
    begin
      case (op)
        `OP_SECTOR_ERASE: limit_of = 25'h00186A0;
        `OP_CHIP_ERASE: limit_of = 25'h007A120;
        default: limit_of = 25'h00061A8;
      endcase
    end
  endfunction

  lock_seq_rom seq_rom (
    .clk(clk),
    .rst(rst),
    .index(seq_reg),
    .lock(op_reg == `OP_LOCK),
    .addr_out(seq_addr)
  );

  assign op_ready = (state_reg == S_IDLE);
  wire is_seq = (op_reg == `OP_UNLOCK) || (op_reg == `OP_LOCK);
  // Two reads with same bit 6 and, for a program only, no complemented bit 7 means finished
  // The sampled byte is used, since the bus is already released in the hold cycle
  wire stable = have_last_reg && (last_reg[`TOGGLE_BIT] == rd_data[`TOGGLE_BIT]) &&
    ((op_reg != `OP_PROGRAM) || (rd_data[`POLL_BIT] == tdata_reg[`POLL_BIT]));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      op_reg <= `OP_READ;
      taddr_reg <= 19'h00000;
      tdata_reg <= 8'h00;
      phase_reg <= 2'h0;
      seq_reg <= 3'h0;
      tcnt_reg <= 3'h0;
      wait_reg <= 25'h0000000;
      last_reg <= 8'h00;
      have_last_reg <= 1'b0;
      polling_reg <= 1'b0;
      done <= 1'b0;
      timeout <= 1'b0;
      rd_data <= 8'h00;
      locked <= 1'b1;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= 19'h00000;
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      timeout <= 1'b0;
      // Count every polling cycle so the limit is real time, not a number of reads
      if (polling_reg && state_reg != S_IDLE) begin
        wait_reg <= wait_reg + 25'h0000001;
      end
      case (state_reg)
        S_IDLE: begin
          ce_n <= 1'b1;
          oe_n <= 1'b1;
          we_n <= 1'b1;
          dq_oe_n <= 1'b1;
          if (op_valid) begin
            op_reg <= op_code;
            taddr_reg <= op_addr;
            tdata_reg <= op_data;
            phase_reg <= 2'h0;
            seq_reg <= 3'h0;
            have_last_reg <= 1'b0;
            polling_reg <= 1'b0;
            wait_reg <= 25'h0000000;
            tcnt_reg <= 3'h0;
            // Program and erase writes while locked would be ignored by the device, so refuse them here
            if ((op_code == `OP_PROGRAM || op_code == `OP_SECTOR_ERASE ||
                op_code == `OP_CHIP_ERASE) && locked) begin
              done <= 1'b1;
              timeout <= 1'b1;
            end else if (op_code == `OP_PROGRAM || op_code == `OP_SECTOR_ERASE ||
                op_code == `OP_CHIP_ERASE || op_code == `OP_ABORT) begin
              state_reg <= S_WSET;
            end else if (op_code <= `OP_LOCK) begin
              state_reg <= S_GAP;
            end else begin
              done <= 1'b1;
            end
          end
        end
        S_WSET: begin
          addr <= (op_reg == `OP_SECTOR_ERASE) ?
            {taddr_reg[`ADDR_W-1:`SECTOR_LSB], 8'h00} : taddr_reg;
          dq_out <= (op_reg == `OP_PROGRAM && phase_reg == 2'h1) ?
            tdata_reg : cmd_of(op_reg, phase_reg);
          dq_oe_n <= 1'b0;
          oe_n <= 1'b1;
          ce_n <= 1'b0;
          tcnt_reg <= 3'h0;
          state_reg <= S_WPULSE;
        end
        S_WPULSE: begin
          we_n <= 1'b0;
          tcnt_reg <= tcnt_reg + 3'h1;
          if (tcnt_reg == `T_SETUP_CYC) begin
            we_n <= 1'b1;
            tcnt_reg <= 3'h0;
            state_reg <= S_WHOLD;
          end
        end
        S_WHOLD: begin
          ce_n <= 1'b1;
          dq_oe_n <= 1'b1;
          if (op_reg == `OP_ABORT) begin
            done <= 1'b1;
            state_reg <= S_IDLE;
          end else if (phase_reg == 2'h0) begin
            phase_reg <= 2'h1;
            state_reg <= S_WSET;
          end else begin
            polling_reg <= 1'b1;
            state_reg <= S_GAP;
          end
        end
        S_GAP: begin
          if (!is_seq) begin
            addr <= taddr_reg;
          end
          state_reg <= S_RSET;
        end
        S_RSET: begin
          // The sequence table answers one clock after its index moves
          if (is_seq) begin
            addr <= seq_addr;
          end
          ce_n <= 1'b0;
          oe_n <= 1'b0;
          we_n <= 1'b1;
          dq_oe_n <= 1'b1;
          tcnt_reg <= 3'h0;
          state_reg <= S_RPULSE;
        end
        S_RPULSE: begin
          tcnt_reg <= tcnt_reg + 3'h1;
          if (tcnt_reg == `T_SETUP_CYC) begin
            rd_data <= dq_in;
            oe_n <= 1'b1;
            state_reg <= S_RHOLD;
          end
        end
        S_RHOLD: begin
          ce_n <= 1'b1;
          if (is_seq) begin
            if (seq_reg == 3'h6) begin
              locked <= (op_reg == `OP_LOCK);
              done <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              seq_reg <= seq_reg + 3'h1;
              state_reg <= S_GAP;
            end
          end else if (!polling_reg) begin
            done <= 1'b1;
            state_reg <= S_IDLE;
          end else if (stable) begin
            done <= 1'b1;
            state_reg <= S_IDLE;
          end else if (wait_reg >= limit_of(op_reg)) begin
            done <= 1'b1;
            timeout <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            last_reg <= rd_data;
            have_last_reg <= 1'b1;
            state_reg <= S_GAP;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== rtl/flash_host_defs.vh ====
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH
`define ADDR_W 19
`define DATA_W 8
`define CMD_SECTOR_SETUP 8'h20
`define CMD_SECTOR_EXEC 8'hD0
`define CMD_CHIP_SETUP 8'h30
`define CMD_CHIP_EXEC 8'h30
`define CMD_PROGRAM_SETUP 8'h10
`define CMD_RESET 8'hFF
`define OP_READ 3'h0
`define OP_PROGRAM 3'h1
`define OP_SECTOR_ERASE 3'h2
`define OP_CHIP_ERASE 3'h3
`define OP_ABORT 3'h4
`define OP_UNLOCK 3'h5
`define OP_LOCK 3'h6
`define SECTOR_LSB 8
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define CLK_MHZ 25
`define T_SETUP_NS 80
`define T_SETUP_CYC ((`T_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define T_SECTOR_MAX_US 4000
`define T_CHIP_MAX_US 20000
`define T_PROG_MAX_US 1000
`define SECTOR_MAX_CYC (`T_SECTOR_MAX_US * `CLK_MHZ)
`define CHIP_MAX_CYC (`T_CHIP_MAX_US * `CLK_MHZ)
`define PROG_MAX_CYC (`T_PROG_MAX_US * `CLK_MHZ)
`endif

// ==== rtl/lock_seq_rom.v ====
`timescale 1ns/10ps
`include "flash_host_defs.vh"
module lock_seq_rom (
  clk,
  rst,
  index,
  lock,
  addr_out
);
  input wire clk;
  input wire rst;
  input wire [2:0] index;
  input wire lock;
  output reg [`ADDR_W-1:0] addr_out;
  reg [`ADDR_W-1:0] addr_next;
  always @* begin
    case (index)
      3'h0: addr_next = 19'h01823;
      3'h1: addr_next = 19'h01820;
      3'h2: addr_next = 19'h01822;
      3'h3: addr_next = 19'h00418;
      3'h4: addr_next = 19'h0041B;
      3'h5: addr_next = 19'h00419;
      3'h6: addr_next = lock ? 19'h0040A : 19'h0041A;
      default: addr_next = 19'h00000;
    endcase
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_out <= 19'h00000;
    end else begin
      addr_out <= addr_next;
    end
  end
endmodule

// ==== tb/flash_dev_model.sv ====
`timescale 1ns/10ps
module flash_dev_model (
  input wire clk,
  input wire [15:0] busy_len,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [18:0] addr,
  input wire [7:0] dq_out,
  output reg [7:0] dq_in
);
  reg [7:0] mem [int];
  reg [18:0] sq [0:5] = '{19'h01823, 19'h01820, 19'h01822, 19'h00418, 19'h0041B, 19'h00419};
  reg [7:0] st = 8'h00;
  reg [7:0] held = 8'h00;
  reg [18:0] wa, la;
  reg lock = 1'b1;
  reg tog = 1'b0;
  integer seq = 0;
  integer busy = 0;
  // Strict compares keep unknown strobes before reset from faking an edge
  wire wr = (ce_n === 1'b0) && (we_n === 1'b0);
  wire rd = (ce_n === 1'b0) && (oe_n === 1'b0) && (we_n === 1'b1);
  function [7:0] rdm(input [18:0] ra);
    rdm = mem.exists(ra) ? mem[ra] : 8'hFF;
  endfunction
  // Internal timer; busy_len lets the bench pick a prompt or a slow part
  always @(negedge clk) if (busy != 0) busy = busy - 1;
  always @(posedge wr) wa = addr;
  always @(negedge rd) begin
    if (seq == 6 && (addr == 19'h0041A || addr == 19'h0040A)) lock = ~addr[4];
    seq = (seq < 6 && addr == sq[seq]) ? seq + 1 : (addr == 19'h01823);
    if (busy != 0) tog = ~tog;
  end
  always @(negedge wr) begin
    if (dq_out == 8'hFF) begin
      st = 8'h00;
      busy = 0;
    end else if (!lock && busy == 0) begin
      if (st == 8'h00) st = (dq_out inside {8'h10, 8'h20, 8'h30}) ? dq_out : 8'h00;
      else begin
        if (st == 8'h20 && dq_out == 8'hD0)
          for (int i = 0; i < 256; i++) mem.delete({13'h0, wa[18:8], i[7:0]});
        if (st == 8'h30 && dq_out == 8'h30) mem.delete();
        if (st == 8'h10) mem[wa] = rdm(wa) & dq_out;
        if (st == 8'h10 || st == 8'h30 || dq_out == 8'hD0) busy = busy_len;
        la = wa;
        st = 8'h00;
      end
    end
  end
  always @(ce_n, oe_n, we_n, addr, busy, tog) begin
    if (ce_n || oe_n) dq_in = ~held;
    else begin
      dq_in = rdm(addr);
      if (busy != 0) dq_in[6] = tog;
      if (busy != 0 && addr == la) dq_in[7] = ~dq_in[7];
      held = dq_in;
    end
  end
endmodule

// ==== tb/flash_host_sva.sv ====
`timescale 1ns/10ps
module flash_host_sva (
  input wire clk,
  input wire rst,
  input wire op_valid,
  input wire [2:0] op_code,
  input wire op_ready,
  input wire done,
  input wire timeout,
  input wire locked,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [18:0] addr,
  input wire [7:0] dq_out,
  input wire dq_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire take = op_valid && op_ready;
  we_sel_a: assert property (!we_n |-> !ce_n) else $error("we without ce");
  we_width_a: assert property ($fell(we_n) |-> !we_n [*2] ##1 we_n) else $error("we width");
  wr_hold_a: assert property (!we_n && $past(!we_n) |-> $stable(addr) && $stable(dq_out))
    else $error("write moved");
  rd_hold_a: assert property (!oe_n && $past(!oe_n) |-> $stable(addr))
    else $error("read addr moved");
  no_mix_a: assert property (!(!we_n && !oe_n)) else $error("read and write mix");
  bus_own_a: assert property (!dq_oe_n |-> oe_n) else $error("bus fight");
  sel_drop_a: assert property ($rose(we_n) |-> ##[0:2] ce_n) else $error("ce kept");
  lock_ref_a: assert property (take && locked && op_code inside {3'h1, 3'h2, 3'h3}
    |=> done && timeout && we_n) else $error("locked write ran");
  to_done_a: assert property (timeout |-> done) else $error("timeout alone");
  unlock_a: assert property (take && op_code == 3'h5 |-> ##[1:200] done && !locked)
    else $error("unlock lost");
  relock_a: assert property (take && op_code == 3'h6 |-> ##[1:200] done && locked)
    else $error("lock lost");
endmodule
bind flash_host flash_host_sva chk_u (.clk(clk), .rst(rst), .op_valid(op_valid),
  .op_code(op_code), .op_ready(op_ready), .done(done), .timeout(timeout), .locked(locked),
  .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "flash_host_defs.vh"
module tb_top;
  reg clk = 0;
  reg rst = 1;
  reg op_valid = 0;
  reg [2:0] op_code = 0;
  reg [18:0] op_addr = 0;
  reg [7:0] op_data = 0;
  reg [15:0] busy_len = 16'h0028;
  wire op_ready, done, timeout, locked, ce_n, oe_n, we_n, dq_oe_n;
  wire [7:0] rd_data, dq_out, dq_in;
  wire [18:0] addr;
  reg [9:0] expq [$];
  reg [18:0] a;
  reg [7:0] d0, d1;
  integer n_errors = 0, cmp_count = 0, seed = 41, k, i;
  always #20 clk = ~clk;
  flash_host dut_u (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_data(op_data), .op_ready(op_ready), .done(done), .timeout(timeout),
    .rd_data(rd_data), .locked(locked), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
    .dq_out(dq_out), .dq_in(dq_in), .dq_oe_n(dq_oe_n));
  flash_dev_model dev_u (.clk(clk), .busy_len(busy_len), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_in(dq_in));
  task test_done;
    begin
      if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task cmp_res(input [9:0] ex);
    begin
      cmp_count = cmp_count + 1;
      if ({ex[9], timeout, ex[9] ? rd_data : 8'h00} !== ex) begin
        n_errors = n_errors + 1;
        $display("mismatch %0t result %b %h", $time, timeout, rd_data);
      end
    end
  endtask
  task cmp_bit(input got, input ex);
    begin
      cmp_count = cmp_count + 1;
      if (got !== ex) begin
        n_errors = n_errors + 1;
        $display("mismatch %0t locked %b", $time, got);
      end
    end
  endtask
  // Bit 9 marks a read whose data is compared, bit 8 the expected timeout
  task run(input [2:0] c, input [18:0] ad, input [7:0] dd, input [9:0] ex);
    begin
      expq.push_back(ex);
      op_valid = 1;
      op_code = c;
      op_addr = ad;
      op_data = dd;
      @(posedge clk);
      #1 op_valid = 0;
      k = 0;
      while (expq.size() != 0 && k < 30000) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 30000) begin
        n_errors = n_errors + 1;
        test_done;
      end
      #1;
    end
  endtask
  always @(posedge clk) begin
    if (done === 1'b1) cmp_res(expq.size() != 0 ? expq.pop_front() : 10'h3FF);
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    cmp_bit(locked, 1'b1);
    a = {$random(seed)} % 19'h7FF00;
    d0 = {$random(seed)} % 255;
    d1 = {$random(seed)} % 255;
    run(`OP_PROGRAM, a, d0, 10'h100);
    run(`OP_READ, a, 8'h00, 10'h2FF);
    run(`OP_UNLOCK, 19'h0, 8'h00, 10'h000);
    cmp_bit(locked, 1'b0);
    run(`OP_PROGRAM, a, d0, 10'h000);
    run(`OP_PROGRAM, a + 19'h100, d1, 10'h000);
    run(`OP_READ, a, 8'h00, {2'b10, d0});
    for (i = 0; i < 2; i = i + 1) begin
      run(`OP_SECTOR_ERASE, a ^ 19'h5A, 8'h00, 10'h000);
      run(`OP_READ, a, 8'h00, 10'h2FF);
      run(`OP_READ, a + 19'h100, 8'h00, {2'b10, d1});
    end
    run(`OP_CHIP_ERASE, a, 8'h00, 10'h000);
    run(`OP_READ, a + 19'h100, 8'h00, 10'h2FF);
    run(`OP_ABORT, a, 8'h00, 10'h000);
    run(`OP_PROGRAM, a, d1, 10'h000);
    run(`OP_READ, a, 8'h00, {2'b10, d1});
    run(`OP_LOCK, 19'h0, 8'h00, 10'h000);
    cmp_bit(locked, 1'b1);
    run(`OP_PROGRAM, a + 19'h200, d0, 10'h100);
    run(`OP_UNLOCK, 19'h0, 8'h00, 10'h000);
    // Slow part outlasts the polling limit of a program
    busy_len = 16'd26000;
    run(`OP_PROGRAM, a + 19'h200, d0, 10'h100);
    test_done;
  end
endmodule
